// *** rtl/tsp_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Power-on alone set means idle awaiting a start with the converter powered.
// - Power-on and start set with snooze and trigger source clear means normal measurement, converter on.
// - Power-on, snooze and trigger source set with start clear means prepared for external start, converter off.
// - All four bits set with no trigger present means suspended waiting for a trigger, converter off.
// - All four bits set with a trigger present means snooze measurement, converter on, also from STOP mode.
// - Power-on and snooze set with trigger source and start clear means software suspended, converter off.
// - Snooze enable reaches a snooze state only when the external trigger source is selected.
// - A falling trigger edge while waiting in CPU STOP mode raises a clock request and starts snooze measurement.
module tsp_ctrl
   import tsp_pkg::*;
#(
   parameter int MEAS_CYCLES = 16
) (
   // Clock and reset
   input  wire logic                       CLK,
   input  wire logic                       RST_N,
   // AHB-Lite slave
   input  wire logic                       HSEL,
   input  wire logic [tsp_pkg::ADDR_W-1:0] HADDR,
   input  wire logic [1:0]                 HTRANS,
   input  wire logic                       HWRITE,
   input  wire logic [2:0]                 HSIZE,
   input  wire logic                       HREADY,
   input  wire logic [tsp_pkg::DATA_W-1:0] HWDATA,
   output var  logic [tsp_pkg::DATA_W-1:0] HRDATA,
   output var  logic                       HREADYOUT,
   output var  logic                       HRESP,
   // Trigger and power-mode inputs
   input  wire logic                       TRIG_N,
   input  wire logic                       CPU_STOP,
   // Converter, clock request, status and interrupt
   output var  logic                       CONV_ON,
   output var  logic                       CLK_REQ,
   output var  logic                       MEAS_BUSY,
   output var  logic                       IRQ
);
   import tsp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Control bits and trigger to unit state
   function automatic tsp_state_t decode_state(input tsp_ctrl_t c, input logic pend);
      tsp_state_t s;
      s = ST_PROHIBITED;
      unique case ({c.power_on_bit, c.snooze_enable_bit,
                    c.trigger_source_select, c.measure_start_bit})
         4'h0: s = ST_STOPPED;
         4'h8: s = ST_IDLE;
         4'h9: s = ST_NORMAL;
         4'he: s = ST_EXT_PREP;
         4'hf: s = pend ? ST_SNOOZE : ST_SUSPEND;
         4'hc: s = ST_SW_SUSP;
         default: s = ST_PROHIBITED;
      endcase
      return s;
   endfunction

   // States in which the sensing supply converter runs
   function automatic logic conv_needed(input tsp_state_t s);
      return (s == ST_IDLE) || (s == ST_NORMAL) || (s == ST_SNOOZE);
   endfunction

   // Word address match for a plain byte address
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
      return a[ADDR_W-1:2] == r[ADDR_W-1:2];
   endfunction

   localparam logic [ADDR_W-1:0] CALIB_LOW_ADDR  = CALIB_LOW_IDX << IDX_SHIFT;
   localparam logic [ADDR_W-1:0] CALIB_HIGH_ADDR = CALIB_HIGH_IDX << IDX_SHIFT;
   localparam int                CNT_W           = $clog2(MEAS_CYCLES + 1);
   localparam logic [CNT_W-1:0]  CNT_LAST        = CNT_W'(MEAS_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   tsp_ahb_req_t       req;
   logic               accept;
   logic               wr_ff;
   logic               rd_ff;
   logic [ADDR_W-1:0]  addr_ff;
   logic               wr_ctrl;
   logic               wr_irq_stat;
   logic               wr_irq_mask;
   logic               wr_cal_lo;
   logic               wr_cal_hi;
   tsp_ctrl_t          ctrl_ff;
   logic [CALIB_W-1:0] calib_low_ff;
   logic [CALIB_W-1:0] calib_high_ff;
   logic [EVT_W-1:0]   irq_stat_ff;
   logic [EVT_W-1:0]   irq_mask_ff;
   logic [EVT_W-1:0]   events;
   tsp_state_t         nxt_state;
   tsp_state_t         state_ff;
   logic               pend_ff;
   logic [CNT_W-1:0]   meas_cnt_ff;
   logic               meas_done;
   logic               trig_s;
   logic               stop_s;
   logic               trig_prev_ff;
   logic               trig_fall;
   logic               wake;
   logic [DATA_W-1:0]  nxt_rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers (trigger idles high, falling edge is active)

   tsp_sync #(
      .WIDTH     (1),
      .RESET_VAL (1'b1)
   ) u_trig_sync (
      .CLK   (CLK),
      .RST_N (RST_N),
      .D_IN  (TRIG_N),
      .Q_OUT (trig_s)
   );

   tsp_sync #(
      .WIDTH     (1),
      .RESET_VAL (1'b0)
   ) u_stop_sync (
      .CLK   (CLK),
      .RST_N (RST_N),
      .D_IN  (CPU_STOP),
      .Q_OUT (stop_s)
   );

   // Edge detect on the filtered trigger
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         trig_prev_ff <= 1'b1;
      end else begin
         trig_prev_ff <= trig_s;
      end
   end

   assign trig_fall = trig_prev_ff & ~trig_s;
   assign wake      = trig_fall && (state_ff == ST_SUSPEND);

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite address and data phase

   assign req    = '{htrans: HTRANS, hwrite: HWRITE, hsize: HSIZE, haddr: HADDR};
   assign accept = HSEL && HREADY && (req.htrans == HTRANS_NSEQ);

   // Address phase capture; reads get one wait state
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         wr_ff     <= 1'b0;
         rd_ff     <= 1'b0;
         addr_ff   <= '0;
         HREADYOUT <= 1'b1;
      end else begin
         if (accept) begin
            wr_ff     <= req.hwrite;
            rd_ff     <= ~req.hwrite;
            addr_ff   <= req.haddr;
            HREADYOUT <= req.hwrite;
         end else begin
            wr_ff     <= 1'b0;
            rd_ff     <= 1'b0;
            HREADYOUT <= 1'b1;
         end
      end
   end

   // Response is always OKAY
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         HRESP <= 1'b0;
      end else begin
         HRESP <= 1'b0;
      end
   end

   assign wr_ctrl     = wr_ff && hit(addr_ff, CTRL_ADDR);
   assign wr_irq_stat = wr_ff && hit(addr_ff, IRQ_STAT_ADDR);
   assign wr_irq_mask = wr_ff && hit(addr_ff, IRQ_MASK_ADDR);
   assign wr_cal_lo   = wr_ff && hit(addr_ff, CALIB_LOW_ADDR);
   assign wr_cal_hi   = wr_ff && hit(addr_ff, CALIB_HIGH_ADDR);

   // Read mux; unmapped addresses read zero
   always_comb begin
      nxt_rdata = '0;
      if (hit(addr_ff, CTRL_ADDR)) begin
         nxt_rdata[CTRL_W-1:0] = ctrl_ff;
      end else if (hit(addr_ff, STAT_ADDR)) begin
         nxt_rdata[STAT_STATE_LSB +: STATE_W] = state_ff;
         nxt_rdata[STAT_CONV_BIT]             = CONV_ON;
         nxt_rdata[STAT_PEND_BIT]             = pend_ff;
         nxt_rdata[STAT_CLKREQ_BIT]           = CLK_REQ;
      end else if (hit(addr_ff, IRQ_STAT_ADDR)) begin
         nxt_rdata[EVT_W-1:0] = irq_stat_ff;
      end else if (hit(addr_ff, IRQ_MASK_ADDR)) begin
         nxt_rdata[EVT_W-1:0] = irq_mask_ff;
      end else if (hit(addr_ff, CALIB_LOW_ADDR)) begin
         nxt_rdata[CALIB_W-1:0] = calib_low_ff;
      end else if (hit(addr_ff, CALIB_HIGH_ADDR)) begin
         nxt_rdata[CALIB_W-1:0] = calib_high_ff;
      end
   end

   // Read data loaded in the wait cycle, after any preceding write landed
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         HRDATA <= '0;
      end else if (rd_ff && !HREADYOUT) begin
         HRDATA <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register; start self-clears at measurement end, a write wins

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_ff <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_ff <= tsp_ctrl_t'(HWDATA[CTRL_W-1:0]);
      end else if (meas_done) begin
         ctrl_ff.measure_start_bit <= 1'b0;
      end
   end

   // Calibration registers, reserved bits held at zero
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         calib_low_ff  <= CALIB_RESET;
         calib_high_ff <= CALIB_RESET;
      end else begin
         if (wr_cal_lo) begin
            calib_low_ff <= HWDATA[CALIB_W-1:0] & CALIB_LOW_RW;
         end
         if (wr_cal_hi) begin
            calib_high_ff <= HWDATA[CALIB_W-1:0] & CALIB_HIGH_RW;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trigger pending and clock request

   // Trigger latched while suspended, dropped at measurement end or on leaving
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pend_ff <= 1'b0;
      end else if (wake) begin
         pend_ff <= 1'b1;
      end else if (meas_done || (ctrl_ff != tsp_ctrl_t'(4'hf))) begin
         pend_ff <= 1'b0;
      end
   end

   // Clock request to the clock generator for a wake from STOP
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         CLK_REQ <= 1'b0;
      end else if (wake && stop_s) begin
         CLK_REQ <= 1'b1;
      end else if (meas_done || (nxt_state != ST_SNOOZE)) begin
         CLK_REQ <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Unit state and converter gate

   assign nxt_state = decode_state(ctrl_ff, pend_ff);

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_ff  <= ST_STOPPED;
         CONV_ON   <= 1'b0;
         MEAS_BUSY <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         CONV_ON   <= conv_needed(nxt_state);
         MEAS_BUSY <= (nxt_state == ST_NORMAL) || (nxt_state == ST_SNOOZE);
      end
   end

   // Measurement length counter
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         meas_cnt_ff <= '0;
      end else if (!MEAS_BUSY || meas_done) begin
         meas_cnt_ff <= '0;
      end else begin
         meas_cnt_ff <= meas_cnt_ff + CNT_W'(1);
      end
   end

   assign meas_done = MEAS_BUSY && (meas_cnt_ff == CNT_LAST)
                      && ((state_ff == ST_NORMAL) || (state_ff == ST_SNOOZE));

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status, mask and output

   assign events[EVT_MEAS_END]   = meas_done;
   assign events[EVT_TRIG_WAKE]  = wake;
   assign events[EVT_PROHIBITED] = (nxt_state == ST_PROHIBITED)
                                   && (state_ff != ST_PROHIBITED);

   // Write one to clear, a new event wins over the clear
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_stat_ff <= EVT_RESET;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~(wr_irq_stat ? HWDATA[EVT_W-1:0] : EVT_RESET))
                        | events;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_mask_ff <= EVT_RESET;
      end else if (wr_irq_mask) begin
         irq_mask_ff <= HWDATA[EVT_W-1:0];
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   a_idle_conv_on: assert property (
      (ctrl_ff == tsp_ctrl_t'(4'h1)) |=> (state_ff == ST_IDLE) && CONV_ON)
      else $error("idle state or converter wrong");

   a_normal_meas_run: assert property (
      (ctrl_ff == tsp_ctrl_t'(4'h9)) |=> (state_ff == ST_NORMAL) && CONV_ON && MEAS_BUSY)
      else $error("normal measurement not running");

   a_ext_prep_off: assert property (
      (ctrl_ff == tsp_ctrl_t'(4'h7)) |=> (state_ff == ST_EXT_PREP) && !CONV_ON)
      else $error("external prepare state wrong");

   a_suspend_wait: assert property (
      (ctrl_ff == tsp_ctrl_t'(4'hf)) && !pend_ff |=> (state_ff == ST_SUSPEND) && !CONV_ON)
      else $error("suspend state wrong");

   a_snooze_meas_on: assert property (
      (ctrl_ff == tsp_ctrl_t'(4'hf)) && pend_ff |=> (state_ff == ST_SNOOZE) && CONV_ON)
      else $error("snooze measurement not running");

   a_sw_susp_off: assert property (
      (ctrl_ff == tsp_ctrl_t'(4'h3)) |=> (state_ff == ST_SW_SUSP) && !CONV_ON)
      else $error("software suspend state wrong");

   a_snooze_needs_ext: assert property (
      !ctrl_ff.trigger_source_select |=>
         !(state_ff inside {ST_EXT_PREP, ST_SUSPEND, ST_SNOOZE}))
      else $error("snooze state without external trigger source");

   a_wake_clk_req: assert property (
      wake && stop_s && (ctrl_ff == tsp_ctrl_t'(4'hf)) && !wr_ctrl
         |=> CLK_REQ && pend_ff ##1 (state_ff == ST_SNOOZE))
      else $error("no clock request or snooze after trigger");

   a_stopped_all_clr: assert property (
      (ctrl_ff == CTRL_RESET) |=> (state_ff == ST_STOPPED) && !CONV_ON && !MEAS_BUSY)
      else $error("stopped state wrong");

   a_irq_level: assert property (
      |(irq_stat_ff & irq_mask_ff) |=> IRQ)
      else $error("interrupt not raised");

endmodule

`default_nettype wire

// *** rtl/tsp_pkg.sv ***
package tsp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus widths and AHB-Lite codes
   localparam int         ADDR_W      = 32;
   localparam int         DATA_W      = 32;
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD  = 3'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Register map (byte addresses)
   localparam logic [ADDR_W-1:0] CTRL_ADDR     = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] STAT_ADDR     = 32'h0000_0004;
   localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 32'h0000_0008;
   localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 32'h0000_000c;
   // Calibration registers: printed offsets are indices, address is index*4
   localparam logic [ADDR_W-1:0] CALIB_LOW_IDX  = 32'h000f_0528;
   localparam logic [ADDR_W-1:0] CALIB_HIGH_IDX = 32'h000f_052a;
   localparam logic [1:0]        IDX_SHIFT      = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values
   localparam int          CTRL_W          = 4;
   localparam int          CALIB_W         = 16;
   localparam int          EVT_W           = 3;
   localparam int          STATE_W         = 3;
   localparam int          EVT_MEAS_END    = 0;
   localparam int          EVT_TRIG_WAKE   = 1;
   localparam int          EVT_PROHIBITED  = 2;
   localparam int          STAT_STATE_LSB  = 0;
   localparam int          STAT_CONV_BIT   = 4;
   localparam int          STAT_PEND_BIT   = 5;
   localparam int          STAT_CLKREQ_BIT = 6;
   localparam logic [15:0] CALIB_LOW_RW    = 16'h0bfc;
   localparam logic [15:0] CALIB_HIGH_RW   = 16'hff00;
   localparam logic [15:0] CALIB_RESET     = 16'h0000;
   localparam logic [2:0]  EVT_RESET       = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic measure_start_bit;
      logic trigger_source_select;
      logic snooze_enable_bit;
      logic power_on_bit;
   } tsp_ctrl_t;

   localparam tsp_ctrl_t CTRL_RESET = '{default: 1'b0};

   typedef enum logic [STATE_W-1:0] {
      ST_STOPPED,
      ST_IDLE,
      ST_NORMAL,
      ST_EXT_PREP,
      ST_SUSPEND,
      ST_SNOOZE,
      ST_SW_SUSP,
      ST_PROHIBITED
   } tsp_state_t;

   typedef struct packed {
      logic [1:0]         htrans;
      logic               hwrite;
      logic [2:0]         hsize;
      logic [ADDR_W-1:0]  haddr;
   } tsp_ahb_req_t;

endpackage

// *** rtl/tsp_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; output follows once stages two and three agree
module tsp_sync #(
   parameter int         WIDTH     = 1,
   parameter logic [0:0] RESET_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic             CLK,
   input  wire logic             RST_N,
   // Asynchronous in, filtered out
   input  wire logic [WIDTH-1:0] D_IN,
   output var  logic [WIDTH-1:0] Q_OUT
);

   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;

   // Capture chain
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s1_ff <= {WIDTH{RESET_VAL}};
         s2_ff <= {WIDTH{RESET_VAL}};
         s3_ff <= {WIDTH{RESET_VAL}};
      end else begin
         s1_ff <= D_IN;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // Accept a bit only when stages two and three agree
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         Q_OUT <= {WIDTH{RESET_VAL}};
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               Q_OUT[i] <= s3_ff[i];
            end
         end
      end
   end

endmodule

`default_nettype wire

// *** verification/tsp_trig_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Trigger source, power-mode source and clock generator beside the controller
module tsp_trig_model #(
   parameter int LOW_CYCLES = 6
) (
   // Clock and reset
   input  wire logic       CLK,
   input  wire logic       RST_N,
   // Commands from the bench
   input  wire logic       FIRE,
   input  wire logic       STOP_IN,
   // Controller side
   input  wire logic       CLK_REQ,
   output var  logic       TRIG_N,
   output var  logic       CPU_STOP,
   // Clock generator grant count
   output var  logic [7:0] GRANTS
);
   int   low_ff;
   logic req_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Falling trigger edge held low for a fixed span, idles high
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         low_ff <= 0;
         TRIG_N <= 1'b1;
      end else if (FIRE) begin
         low_ff <= LOW_CYCLES;
         TRIG_N <= 1'b0;
      end else if (low_ff > 1) begin
         low_ff <= low_ff - 1;
      end else begin
         low_ff <= 0;
         TRIG_N <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // CPU power mode level
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         CPU_STOP <= 1'b0;
      end else begin
         CPU_STOP <= STOP_IN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock generator counts each new request
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         req_ff <= 1'b0;
         GRANTS <= 8'h00;
      end else begin
         req_ff <= CLK_REQ;
         if (CLK_REQ && !req_ff) begin
            GRANTS <= GRANTS + 8'h01;
         end
      end
   end
endmodule

`default_nettype wire

// *** verification/touch_sense_power_state_ctrl_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module touch_sense_power_state_ctrl_bench;
   import tsp_pkg::*;

   localparam int          MEAS_N = 8;
   localparam logic [31:0] CAL_LO = CALIB_LOW_IDX << IDX_SHIFT;
   localparam logic [31:0] CAL_HI = CALIB_HIGH_IDX << IDX_SHIFT;

   // Bench-driven inputs
   logic        clk, rst_n, hsel, hwrite, fire, stop;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata;
   // Design and model outputs
   logic [31:0] hrdata, rdat;
   logic        hreadyout, hresp, trig_n, cpu_stop, conv_on, clk_req, meas_busy, irq;
   logic [7:0]  grants;
   int          n_errors, checks_done, n, i;
   logic [31:0] rst_tab [5];
   logic [31:0] es;

   tsp_ctrl #(.MEAS_CYCLES(MEAS_N)) tsp_ctrl_i (
      .CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hreadyout), .HWDATA(hwdata),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .TRIG_N(trig_n),
      .CPU_STOP(cpu_stop), .CONV_ON(conv_on), .CLK_REQ(clk_req),
      .MEAS_BUSY(meas_busy), .IRQ(irq)
   );

   tsp_trig_model tsp_trig_model_i (
      .CLK(clk), .RST_N(rst_n), .FIRE(fire), .STOP_IN(stop), .CLK_REQ(clk_req),
      .TRIG_N(trig_n), .CPU_STOP(cpu_stop), .GRANTS(grants)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare, verdict and bus tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic bus(input logic wr_en, input logic [31:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd_out);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= HTRANS_NSEQ;
      hwrite <= wr_en;
      haddr  <= addr;
      hsize  <= HSIZE_WORD;
      // Waits on ready with no limit; only the watchdog ends a hang
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         @(posedge clk);
      end
      hsel   <= 1'b0;
      htrans <= HTRANS_IDLE;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         @(posedge clk);
      end
      rd_out = hrdata;
   endtask

   task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
      logic [31:0] dummy;
      bus(1'b1, addr, wd, dummy);
   endtask

   task automatic rdchk(input logic [31:0] addr, input logic [31:0] exp);
      bus(1'b0, addr, 32'h0, rdat);
      check(rdat, exp);
   endtask

   // Waits for a measurement and counts its busy cycles
   task automatic meas_len(output int len);
      int k;
      k = 0;
      len = 0;
      while (meas_busy !== 1'b1 && k < 30) begin
         @(posedge clk);
         k++;
      end
      check({31'h0, conv_on}, 32'h1);
      while (meas_busy === 1'b1 && len < 50) begin
         @(posedge clk);
         len++;
      end
   endtask

   task automatic pulse_fire();
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
   endtask

   // Status expected for a control code: converter bit4, state bits 2:0
   function automatic logic [31:0] exp_stat(input logic [3:0] c);
      logic [2:0] s;
      case (c)
         4'h0: s = 3'h0;
         4'h1: s = 3'h1;
         4'h9: s = 3'h2;
         4'h7: s = 3'h3;
         4'hf: s = 3'h4;
         4'h3: s = 3'h6;
         default: s = 3'h7;
      endcase
      return {27'h0, (s == 3'h1 || s == 3'h2), 1'b0, s};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      #(5000 * 40);
      n_errors++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst_n = 1'b0; hsel = 1'b0; hwrite = 1'b0; fire = 1'b0; stop = 1'b0;
      htrans = HTRANS_IDLE; hsize = HSIZE_WORD; haddr = 32'h0; hwdata = 32'h0;
      n_errors = 0; checks_done = 0;
      rst_tab = '{CTRL_ADDR, STAT_ADDR, IRQ_STAT_ADDR, IRQ_MASK_ADDR, CAL_LO};
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // Quiet outputs and zero registers after reset
      check({26'h0, hreadyout, hresp, conv_on, clk_req, meas_busy, irq}, 32'h20);
      for (i = 0; i < 5; i++) rdchk(rst_tab[i], 32'h0);
      // Calibration writable masks and an unmapped word
      wr(CAL_LO, 32'hffff_ffff);
      rdchk(CAL_LO, {16'h0, CALIB_LOW_RW});
      wr(CAL_HI, 32'hffff_ffff);
      rdchk(CAL_HI, {16'h0, CALIB_HIGH_RW});
      wr(32'h10, 32'hffff_ffff);
      rdchk(32'h10, 32'h0);
      // Every control code decoded
      for (i = 0; i < 16; i++) begin
         wr(CTRL_ADDR, 32'(i));
         repeat (3) @(posedge clk);
         es = exp_stat(4'(i));
         rdchk(STAT_ADDR, es);
         check({30'h0, conv_on, meas_busy}, {30'h0, es[4], i == 9});
         if (i == 9) begin
            meas_len(n);
            rdchk(CTRL_ADDR, 32'h1);
         end
         wr(CTRL_ADDR, 32'h0);
      end
      // Interrupt status, mask and clear
      rdchk(IRQ_STAT_ADDR, 32'h5);
      wr(IRQ_MASK_ADDR, 32'h4);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h1);
      wr(IRQ_STAT_ADDR, 32'h4);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h0);
      rdchk(IRQ_STAT_ADDR, 32'h1);
      wr(IRQ_STAT_ADDR, 32'h1);
      // Leave software suspend: snooze off, then start
      wr(CTRL_ADDR, 32'h3);
      wr(CTRL_ADDR, 32'h1);
      wr(CTRL_ADDR, 32'h9);
      meas_len(n);
      // Busy spans the counted cycles plus the cycle in which start clears
      check(32'(n), 32'(MEAS_N + 1));
      rdchk(CTRL_ADDR, 32'h1);
      // Trigger while only prepared is ignored
      wr(CTRL_ADDR, 32'h7);
      pulse_fire();
      repeat (15) @(posedge clk);
      check({31'h0, meas_busy}, 32'h0);
      rdchk(IRQ_STAT_ADDR, 32'h1);
      wr(IRQ_STAT_ADDR, 32'h1);
      // Snooze wake from STOP mode
      wr(IRQ_MASK_ADDR, 32'h3);
      stop <= 1'b1;
      wr(CTRL_ADDR, 32'hf);
      repeat (6) @(posedge clk);
      rdchk(STAT_ADDR, 32'h4);
      check({31'h0, conv_on}, 32'h0);
      pulse_fire();
      n = 0;
      while (clk_req !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      check({31'h0, clk_req}, 32'h1);
      meas_len(n);
      check(32'(n), 32'(MEAS_N + 1));
      check({30'h0, clk_req, irq}, 32'h1);
      check({24'h0, grants}, 32'h1);
      rdchk(STAT_ADDR, 32'h3);
      rdchk(IRQ_STAT_ADDR, 32'h3);
      // Software turns snooze off after the end interrupt
      wr(CTRL_ADDR, 32'h1);
      wr(IRQ_STAT_ADDR, 32'h3);
      rdchk(IRQ_STAT_ADDR, 32'h0);
      check({31'h0, irq}, 32'h0);
      close_out();
   end
endmodule

`default_nettype wire
